// *** hdl/i2cs_cfg.svh ***
// constants of the two-wire slave register port
// Behaviour
// - acts only as addressed slave; never makes clock, never arbitrates
// - never holds the clock line low; master times every bit
// - general call, device ID and high-speed mode are never answered
// - glitch filters on clock and data while the host port is selected
// - data driven changes only while clock is low, except the short-reach release after the clock rises
// - falling data with clock high is start; rising data is stop
// - bus busy from start to stop; repeated start restarts address phase
// - bytes travel msb first, each followed by one acknowledge bit
// - receiver pulls data low through acknowledge clock, in short-reach mode only until it rises; sender releases
// - after master's missing acknowledge the device releases data
// - address is 01010 plus two bits from straps or configuration
// - writes to the fifo address keep the pointer, every byte to fifo
// - read returns pointed register, pointer advances except at fifo
// - short-reach link: master drives clock push-pull, no stretching
// - short-reach link: keeper holds data, one slave only
// - short-reach link: nobody drives data while clock is high; this slave keeps driving until it sees the synchronised rise
// - short-reach pin addressing forces the upper selectable bit to 0
`ifndef I2CS_CFG_SVH
`define I2CS_CFG_SVH
`define I2CS_ADDR_HI 5'h0a
`define I2CS_FIFO_ADDR 8'h05
`define I2CS_FILT_CYC 2
`define I2CS_PTR_RST 8'h00
`endif

// *** hdl/i2cs_pkg.sv ***
// types of the two-wire slave register port
package i2cs_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_RX = 3'b011,
		ST_RX_ACK = 3'b100,
		ST_TX = 3'b101,
		ST_TX_ACK = 3'b110,
		ST_IGNORE = 3'b111
	} i2cs_state_t;

	typedef struct packed {
		i2cs_state_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic rw;
		logic have_ptr;
		logic [7:0] ptr;
		logic [7:0] txb;
		logic ack_ph;
		logic more;
		logic rd_pend;
		logic [1:0] adr_lo;
		logic strap_done;
		logic [2:0] tog_s;
		logic tog_seen;
		logic scl_d;
		logic sda_d;
		logic sda_o;
		logic sda_oe;
		logic [7:0] reg_addr;
		logic [7:0] wr_data;
		logic wr_stb;
		logic rd_stb;
		logic busy;
	} i2cs_core_t;

	typedef struct packed {
		logic bit_v;
		logic tog;
	} i2cs_link_t;

	typedef struct packed {
		logic [2:0] sync;
		logic [3:0] cnt;
		logic out;
	} i2cs_filt_t;
endpackage : i2cs_pkg

// *** hdl/i2cs_filter.sv ***
// pin synchroniser with spike suppression
`timescale 1ns/1ps
`include "i2cs_cfg.svh"
module i2cs_filter import i2cs_pkg::*; #(
	parameter int FILT_CYC = `I2CS_FILT_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic en,
	// pin and clean level
	input wire logic din,
	output logic dout
);
	i2cs_filt_t s_q;
	i2cs_filt_t s_d;
	logic agree;

	always_comb begin
		s_d = s_q;
		s_d.sync = {s_q.sync[1:0], din};
		agree = s_q.sync[1] == s_q.sync[2];
		if (!agree || s_q.sync[2] == s_q.out) begin
			s_d.cnt = 4'h0;
		end else if (!en || s_q.cnt >= 4'(FILT_CYC - 1)) begin
			// with filtering off a level is accepted at once; otherwise it must hold for the full window
			s_d.out = s_q.sync[2];
			s_d.cnt = 4'h0;
		end else begin
			s_d.cnt = s_q.cnt + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{sync: 3'h7, cnt: 4'h0, out: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	assign dout = s_q.out;
endmodule : i2cs_filter

// *** hdl/i2cs_port.sv ***
// two-wire slave giving a host byte access to the register space
`timescale 1ns/1ps
`include "i2cs_cfg.svh"
module i2cs_port import i2cs_pkg::*; #(
	parameter logic [7:0] FIFO_ADDR = `I2CS_FIFO_ADDR
) (
	// core clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// link clock (the serial clock pin) and data pin
	input wire logic scl_clk,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// configuration
	input wire logic port_sel,
	input wire logic short_reach_point_link,
	input wire logic addr_from_nv,
	input wire logic [1:0] nv_addr,
	input wire logic [1:0] adr_pins,
	// register space
	output logic [7:0] reg_addr,
	output logic reg_wr_stb,
	output logic [7:0] reg_wr_data,
	output logic reg_rd_stb,
	input wire logic [7:0] reg_rd_data,
	// status
	output logic bus_busy
);
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic f_scl;
	logic f_sda;
	i2cs_link_t l_q;
	i2cs_core_t s_q;
	i2cs_core_t s_d;
	logic [7:0] byte_in;
	logic [6:0] my_addr;
	logic ev_rise;
	logic ev_fall;
	logic ev_start;
	logic ev_stop;

	// reset release through two flops
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	i2cs_filter u_scl_filt (
		.clk(core_clk),
		.rst_n(rst_n),
		.en(port_sel),
		.din(scl_clk),
		.dout(f_scl)
	);

	i2cs_filter u_sda_filt (
		.clk(core_clk),
		.rst_n(rst_n),
		.en(port_sel),
		.din(sda_i),
		.dout(f_sda)
	);

	// link side: data sampled on the master's rising clock edge
	always_ff @(posedge scl_clk or negedge nrst) begin
		if (!nrst) begin
			l_q <= '{bit_v: 1'b1, tog: 1'b0};
		end else begin
			l_q.bit_v <= sda_i;
			l_q.tog <= ~l_q.tog;
		end
	end

	assign my_addr = {`I2CS_ADDR_HI, s_q.adr_lo};
	assign byte_in = {s_q.sh[6:0], l_q.bit_v};
	// bit value stays put for a whole clock period, far beyond the sync delay
	assign ev_rise = (s_q.tog_s[1] == s_q.tog_s[2]) &&
		(s_q.tog_s[2] != s_q.tog_seen);
	assign ev_fall = s_q.scl_d && !f_scl;
	assign ev_start = f_scl && s_q.scl_d && s_q.sda_d && !f_sda;
	assign ev_stop = f_scl && s_q.scl_d && !s_q.sda_d && f_sda;

	function automatic i2cs_core_t drive(input i2cs_core_t c,
		input logic en, input logic val, input logic short_mode);
		i2cs_core_t r;
		r = c;
		if (short_mode) begin
			r.sda_oe = en;
			r.sda_o = val;
		end else begin
			r.sda_oe = en && !val;
			r.sda_o = 1'b0;
		end
		return r;
	endfunction : drive

	function automatic logic [7:0] next_ptr(input logic [7:0] p);
		return (p == FIFO_ADDR) ? p : p + 8'h01;
	endfunction : next_ptr

	always_comb begin
		s_d = s_q;
		s_d.wr_stb = 1'b0;
		s_d.rd_stb = 1'b0;
		s_d.scl_d = f_scl;
		s_d.sda_d = f_sda;
		s_d.tog_s = {s_q.tog_s[1:0], l_q.tog};
		if (ev_rise) begin
			s_d.tog_seen = s_q.tog_s[2];
		end
		if (!s_q.strap_done) begin
			s_d.strap_done = 1'b1;
			if (addr_from_nv) begin
				s_d.adr_lo = nv_addr;
			end else if (short_reach_point_link) begin
				s_d.adr_lo = {1'b0, adr_pins[0]};
			end else begin
				s_d.adr_lo = adr_pins;
			end
		end
		if (s_q.rd_pend) begin
			s_d.txb = reg_rd_data;
			s_d.rd_pend = 1'b0;
		end
		if (!port_sel) begin
			s_d.st = ST_IDLE;
			s_d.busy = 1'b0;
			s_d = drive(s_d, 1'b0, 1'b1, short_reach_point_link);
		end else if (ev_start) begin
			// repeated start is the same as a fresh one
			s_d.st = ST_ADDR;
			s_d.cnt = 4'h0;
			s_d.have_ptr = 1'b0;
			s_d.ack_ph = 1'b0;
			s_d.more = 1'b0;
			s_d.busy = 1'b1;
			s_d = drive(s_d, 1'b0, 1'b1, short_reach_point_link);
		end else if (ev_stop) begin
			s_d.st = ST_IDLE;
			s_d.busy = 1'b0;
			s_d = drive(s_d, 1'b0, 1'b1, short_reach_point_link);
		end else if (ev_rise) begin
			if (short_reach_point_link) begin
				s_d.sda_oe = 1'b0;
			end
			case (s_q.st)
				ST_ADDR: begin
					s_d.sh = byte_in;
					s_d.cnt = s_q.cnt + 4'h1;
					if (s_q.cnt == 4'h7) begin
						if (byte_in[7:1] == my_addr) begin
							s_d.st = ST_ADDR_ACK;
							s_d.rw = byte_in[0];
							if (byte_in[0]) begin
								s_d.rd_stb = 1'b1;
								s_d.reg_addr = s_q.ptr;
								s_d.rd_pend = 1'b1;
								s_d.ptr = next_ptr(s_q.ptr);
							end
						end else begin
							s_d.st = ST_IGNORE;
						end
					end
				end
				ST_RX: begin
					s_d.sh = byte_in;
					s_d.cnt = s_q.cnt + 4'h1;
					if (s_q.cnt == 4'h7) begin
						s_d.st = ST_RX_ACK;
						if (!s_q.have_ptr) begin
							s_d.ptr = byte_in;
							s_d.have_ptr = 1'b1;
						end else begin
							s_d.wr_stb = 1'b1;
							s_d.reg_addr = s_q.ptr;
							s_d.wr_data = byte_in;
							s_d.ptr = next_ptr(s_q.ptr);
						end
					end
				end
				ST_TX: begin
					s_d.cnt = s_q.cnt + 4'h1;
					if (s_q.cnt == 4'h7) begin
						s_d.st = ST_TX_ACK;
					end
				end
				ST_TX_ACK: begin
					if (s_q.ack_ph) begin
						if (l_q.bit_v) begin
							s_d.st = ST_IGNORE;
						end else begin
							s_d.rd_stb = 1'b1;
							s_d.reg_addr = s_q.ptr;
							s_d.rd_pend = 1'b1;
							s_d.ptr = next_ptr(s_q.ptr);
							s_d.more = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end else if (ev_fall) begin
			case (s_q.st)
				ST_ADDR_ACK, ST_RX_ACK: begin
					if (!s_q.ack_ph) begin
						s_d.ack_ph = 1'b1;
						s_d = drive(s_d, 1'b1, 1'b0, short_reach_point_link);
					end else begin
						s_d.ack_ph = 1'b0;
						s_d.cnt = 4'h0;
						if (s_q.st == ST_ADDR_ACK && s_q.rw) begin
							s_d.st = ST_TX;
							s_d = drive(s_d, 1'b1, s_q.txb[7], short_reach_point_link);
							s_d.txb = {s_q.txb[6:0], 1'b0};
						end else begin
							s_d.st = ST_RX;
							s_d = drive(s_d, 1'b0, 1'b1, short_reach_point_link);
						end
					end
				end
				ST_TX: begin
					s_d = drive(s_d, 1'b1, s_q.txb[7], short_reach_point_link);
					s_d.txb = {s_q.txb[6:0], 1'b0};
				end
				ST_TX_ACK: begin
					if (!s_q.ack_ph) begin
						s_d.ack_ph = 1'b1;
						s_d = drive(s_d, 1'b0, 1'b1, short_reach_point_link);
					end else if (s_q.more) begin
						s_d.ack_ph = 1'b0;
						s_d.more = 1'b0;
						s_d.cnt = 4'h0;
						s_d.st = ST_TX;
						s_d = drive(s_d, 1'b1, s_q.txb[7], short_reach_point_link);
						s_d.txb = {s_q.txb[6:0], 1'b0};
					end
				end
				default: begin
					s_d = drive(s_d, 1'b0, 1'b1, short_reach_point_link);
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{st: ST_IDLE, cnt: 4'h0, sh: 8'h00, rw: 1'b0,
				have_ptr: 1'b0, ptr: `I2CS_PTR_RST, txb: 8'h00,
				ack_ph: 1'b0, more: 1'b0, rd_pend: 1'b0, adr_lo: 2'h0,
				strap_done: 1'b0, tog_s: 3'h0, tog_seen: 1'b0,
				scl_d: 1'b1, sda_d: 1'b1, sda_o: 1'b0, sda_oe: 1'b0,
				reg_addr: 8'h00, wr_data: 8'h00, wr_stb: 1'b0,
				rd_stb: 1'b0, busy: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// no clock output exists: the master alone times every bit
	assign sda_o = s_q.sda_o;
	assign sda_oe = s_q.sda_oe;
	assign reg_addr = s_q.reg_addr;
	assign reg_wr_stb = s_q.wr_stb;
	assign reg_wr_data = s_q.wr_data;
	assign reg_rd_stb = s_q.rd_stb;
	assign bus_busy = s_q.busy;
endmodule : i2cs_port

// *** testbench/i2cs_port_asserts.sv ***
// concurrent checks on the ports of the two-wire slave
`timescale 1ns/1ps
module i2cs_port_asserts (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// link
	input wire logic scl_clk,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic short_reach_point_link,
	// register side and status
	input wire logic reg_wr_stb,
	input wire logic reg_rd_stb,
	input wire logic bus_busy
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	chk_od_low: assert property (
		sda_oe && !short_reach_point_link |-> !sda_o)
		else $error("data driven high in open-drain mode");
	chk_drive_stable: assert property (
		!short_reach_point_link && scl_clk && $past(scl_clk)
		|-> $stable(sda_oe)) else $error("data drive moved with clock high");
	chk_drive_low: assert property ($rose(sda_oe) |-> !scl_clk)
		else $error("data drive started with clock high");
	chk_idle_release: assert property (!bus_busy |-> !sda_oe)
		else $error("data driven while bus free");
	chk_strobe_busy: assert property (
		reg_wr_stb || reg_rd_stb |-> bus_busy)
		else $error("register strobe outside a frame");
	chk_rw_excl: assert property (!(reg_wr_stb && reg_rd_stb))
		else $error("read and write strobe together");
	chk_strobe_space: assert property (
		reg_wr_stb || reg_rd_stb |=> !(reg_wr_stb || reg_rd_stb) [*8])
		else $error("strobes closer than one byte");
	chk_busy_start: assert property (
		$fell(sda_i) && scl_clk && $past(scl_clk) |-> ##[2:12] bus_busy)
		else $error("start not seen");
	chk_busy_stop: assert property (
		$rose(sda_i) && scl_clk && $past(scl_clk) |-> ##[2:12] !bus_busy)
		else $error("stop not seen");
endmodule : i2cs_port_asserts

// *** testbench/i2cs_master_model.sv ***
// bus master model driving the serial clock and pulling data low
`timescale 1ns/1ps
module i2cs_master_model (
	// wire
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// data moves only mid-low; 200 ns low and high phases
	task automatic bitx(input logic b, output logic r);
		#100 sda_low = !b;
		#100 scl = 1'b1;
		#100 r = sda;
		#100 scl = 1'b0;
	endtask : bitx
	task automatic start();
		#100 sda_low = 1'b0;
		#100 scl = 1'b1;
		#200 sda_low = 1'b1;
		#200 scl = 1'b0;
	endtask : start
	task automatic stop();
		#100 sda_low = 1'b1;
		#100 scl = 1'b1;
		#200 sda_low = 1'b0;
		#200;
	endtask : stop
	task automatic byte_w(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
		end
		bitx(1'b1, ack);
	endtask : byte_w
	task automatic byte_r(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, d[i]);
		end
		bitx(nack, r);
	endtask : byte_r
endmodule : i2cs_master_model

// *** testbench/tb.sv ***
// self-checking bench of the two-wire slave register port
`timescale 1ns/1ps
`include "i2cs_cfg.svh"
module tb;
	import i2cs_pkg::*;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic scl, m_low, sda, sda_o, sda_oe, ack, wr, rd, busy;
	logic [1:0] nv = 2'h0, pins = 2'h0;
	logic [7:0] ra, wd, rdd, a, d, p;
	logic [6:0] dev;
	logic [16:0] q[$];
	logic [16:0] e;
	int fails = 0, checks = 0, cyc = 0, seed = 32'hf1ee1a4f;
	always #12.5 core_clk = !core_clk;
	assign sda = !(m_low || (sda_oe && !sda_o));
	assign rdd = ra ^ 8'h5a;
	i2cs_master_model i2cs_master_model_i (.scl(scl), .sda_low(m_low),
		.sda(sda));
	i2cs_port i2cs_port_i (.core_clk(core_clk), .nrst(nrst), .scl_clk(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .port_sel(1'b1),
		.short_reach_point_link(1'b0), .addr_from_nv(1'b1), .nv_addr(nv),
		.adr_pins(pins), .reg_addr(ra), .reg_wr_stb(wr), .reg_wr_data(wd),
		.reg_rd_stb(rd), .reg_rd_data(rdd), .bus_busy(busy));
	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("fails %0d checks %0d", fails, checks);
		if (fails == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop
	function automatic logic [7:0] nxt(input logic [7:0] x);
		return (x == `I2CS_FIFO_ADDR) ? x : x + 8'h01;
	endfunction : nxt
	// strobes are looked at mid-cycle, away from the edge that launches them
	always @(negedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			report_and_stop();
		end
		if (wr === 1'b1 || rd === 1'b1) begin
			if (q.size() == 0) check({wr, ra, wd}, 17'h0_0000);
			else begin
				e = q.pop_front();
				check({wr, ra, wr ? wd : 8'h00}, e);
			end
		end
	end
	initial begin
		nv = 2'($random(seed));
		pins = ~nv;
		dev = {5'(`I2CS_ADDR_HI), nv};
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (20) @(posedge core_clk);
		i2cs_master_model_i.start();
		check({16'h0, busy}, 17'h1);
		i2cs_master_model_i.byte_w({dev, 1'b0}, ack);
		check({16'h0, ack}, 17'h0);
		i2cs_master_model_i.byte_w(8'h03, ack);
		a = 8'h03;
		for (int i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			q.push_back({1'b1, a, d});
			i2cs_master_model_i.byte_w(d, ack);
			check({16'h0, ack}, 17'h0);
			a = nxt(a);
		end
		i2cs_master_model_i.stop();
		check({16'h0, busy}, 17'h0);
		for (int i = 0; i < 2; i++) begin
			a = i ? 8'h04 : 8'h10;
			i2cs_master_model_i.start();
			i2cs_master_model_i.byte_w({dev, 1'b0}, ack);
			i2cs_master_model_i.byte_w(a, ack);
			p = a;
			for (int k = 0; k < 3; k++) begin
				q.push_back({1'b0, p, 8'h00});
				p = nxt(p);
			end
			i2cs_master_model_i.start();
			i2cs_master_model_i.byte_w({dev, 1'b1}, ack);
			for (int k = 0; k < 3; k++) begin
				i2cs_master_model_i.byte_r(k == 2, d);
				check({9'h0, d}, {9'h0, a ^ 8'h5a});
				a = nxt(a);
			end
			i2cs_master_model_i.stop();
		end
		for (int i = 0; i < 2; i++) begin
			i2cs_master_model_i.start();
			i2cs_master_model_i.byte_w(i ? 8'h00 : {5'(`I2CS_ADDR_HI), ~nv,
				1'b0}, ack);
			check({16'h0, ack}, 17'h1);
			i2cs_master_model_i.byte_w(8'h33, ack);
			i2cs_master_model_i.stop();
		end
		repeat (20) @(posedge core_clk);
		check({16'h0, q.size() == 0}, 17'h1);
		report_and_stop();
	end
endmodule : tb
bind i2cs_port i2cs_port_asserts i2cs_port_asserts_i (.core_clk(core_clk),
	.nrst(nrst), .scl_clk(scl_clk), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe(sda_oe), .short_reach_point_link(short_reach_point_link),
	.reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .bus_busy(bus_busy));
